// file: afr_pkg.sv
// Purpose: Shared constants, types and frame layout for the converter
//          readout link (converter end and host end).
// Assumes: Both ends sample the link on the rising edge of the link clock.
package afr_pkg;

   localparam int unsigned WORD_W      = 8;
   localparam int unsigned N_CH        = 2;
   localparam int unsigned FRAME_WORDS = N_CH + 1;
   localparam int unsigned FRAME_BITS  = FRAME_WORDS * WORD_W;
   localparam int unsigned FIFO_DEPTH  = 2;
   localparam int unsigned CNT_W       = 6;
   localparam int unsigned BIT_W       = 5;

   // Conversion period in link clocks and the point where ready is released
   localparam logic [CNT_W-1:0] PERIOD_LAST = 6'h3F;
   localparam logic [CNT_W-1:0] CONVERSION_DONE_N_RISE   = 6'h3E;
   localparam logic [CNT_W-1:0] CNT_RST     = 6'h00;

   localparam logic [BIT_W-1:0] FRAME_LAST  = 5'h17;
   localparam logic [BIT_W-1:0] BIT_RST     = 5'h00;

   localparam logic [1:0]        LVL_EMPTY  = 2'h0;
   localparam logic [1:0]        LVL_ONE    = 2'h1;
   localparam logic [1:0]        LVL_FULL   = 2'h2;
   localparam logic [WORD_W-1:0] IDX_RST    = 8'h00;
   localparam logic [6:0]        STAT_PAD   = 7'h00;
   localparam logic              PIN_IDLE   = 1'b1;

   typedef enum logic [1:0]
   {
      AFR_IDLE = 2'b00,
      AFR_READ = 2'b01
   } afr_hstate_t;

   // Frame: status word first, then one word per channel, MSB first
   function automatic logic [FRAME_BITS-1:0] afr_frame
   (
      input logic [WORD_W-1:0] idx,
      input logic              flag
   );
      logic [FRAME_BITS-1:0] f;
      f = '0;
      f[FRAME_BITS-1 -: WORD_W] = {flag, STAT_PAD};
      for (int c = 0; c < N_CH; c++)
      begin
         f[(N_CH-1-c)*WORD_W +: WORD_W] = idx + WORD_W'(c);
      end
      return f;
   endfunction

endpackage

// file: afr_link_if.sv
// Purpose: Link between converter end and host end.
// Assumes: Data line is pulled high when no device drives it.
// Notes:   The shared data line level is resolved here from the enable.
`timescale 1ns/1ns
interface afr_link_if
(
   input  logic lk_clk
);
   logic cs_n;
   logic sync_n;
   logic dout;
   logic dout_oe;
   logic dout_line;
   logic conversion_done_n;

   assign dout_line = dout_oe ? dout : 1'b1;

   modport dev
   (
      input  lk_clk,
      input  cs_n,
      input  sync_n,
      output dout,
      output dout_oe,
      output conversion_done_n
   );

   modport host
   (
      input  lk_clk,
      input  dout_line,
      input  conversion_done_n,
      output cs_n,
      output sync_n
   );
endinterface

// file: afr_dev.sv
// Purpose: Converter end: conversion timing, two-deep result FIFO,
//          serial frame output, strobe alignment check.
// Assumes: Everything runs on the link clock; host pins are on that clock.
// Notes:   Results are synthetic: a conversion index plus channel number.
`timescale 1ns/1ns
module afr_dev
   import afr_pkg::*;
(
   afr_link_if.dev              lk,
   input  wire logic            nrst_i,
   output logic                 realign_flag_o,
   output logic [1:0]           fifo_level_o,
   output logic                 overflow_o,
   output logic                 frame_read_o,
   output logic                 partial_read_o,
   output logic [WORD_W-1:0]    conv_count_o
);

   logic [CNT_W-1:0]  per_cnt_r;
   logic              sync_q_r;
   logic              sync_fall;
   logic              aligned;
   logic              conv;
   logic              misalign;
   logic [WORD_W-1:0] mem_r [FIFO_DEPTH];
   logic              rd_ptr_r;
   logic              wr_ptr_r;
   logic [1:0]        level_r;
   logic [WORD_W-1:0] conv_idx_r;
   logic              pop;
   logic              full_ovf;
   logic [BIT_W-1:0]  bit_idx_r;
   logic              frame_done;
   logic [FRAME_BITS-1:0] frame_w;
   logic              dout_r;
   logic              dout_oe_r;
   logic              conversion_done_n_n_r;
   logic              flag_r;
   logic              ovf_r;
   logic              rd_done_r;
   logic              part_r;

   // One decode of the period end serves both the conversion and the
   // phase at which a strobe is expected
   function automatic logic at_period_end(input logic [CNT_W-1:0] c);
      return (c == PERIOD_LAST);
   endfunction

   assign sync_fall  = sync_q_r & ~lk.sync_n;
   assign aligned    = at_period_end(per_cnt_r);
   assign conv       = at_period_end(per_cnt_r);
   assign misalign   = sync_fall & ~aligned;
   assign frame_done = ~lk.cs_n & (bit_idx_r == FRAME_LAST);
   assign pop        = frame_done & (level_r != LVL_EMPTY);
   assign full_ovf   = conv & (level_r == LVL_FULL) & ~pop;
   assign frame_w    = afr_frame(mem_r[rd_ptr_r], flag_r);

   // Strobe edge detector; the strobe is on this clock, so no synchroniser
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         sync_q_r <= PIN_IDLE;
      else
         sync_q_r <= lk.sync_n;
   end

   // Period counter: a strobe at the expected phase changes nothing,
   // a misplaced one restarts the period without converting
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         per_cnt_r <= CNT_RST;
      else if (conv || misalign)
         per_cnt_r <= CNT_RST;
      else
         per_cnt_r <= per_cnt_r + 6'h01;
   end

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         conv_idx_r <= IDX_RST;
      else if (conv)
         conv_idx_r <= conv_idx_r + 8'h01;
   end

   // Result storage; on overflow the unread pair is dropped and the new
   // result becomes the only entry, so ready pulses every other period
   always_ff @(posedge lk.lk_clk)
   begin
      if (conv)
      begin
         if (full_ovf)
            mem_r[rd_ptr_r] <= conv_idx_r;
         else
            mem_r[wr_ptr_r] <= conv_idx_r;
      end
   end

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
      end
      else if (full_ovf)
      begin
         wr_ptr_r <= ~rd_ptr_r;
      end
      else
      begin
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (conv)
            wr_ptr_r <= ~wr_ptr_r;
      end
   end

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         level_r <= LVL_EMPTY;
      else if (full_ovf)
         level_r <= LVL_ONE;
      else if (conv && !pop)
         level_r <= level_r + 2'h1;
      else if (pop && !conv)
         level_r <= level_r - 2'h1;
   end

   // Bit pointer: a select that rises early discards progress, so the
   // same result is presented again from its first bit
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         bit_idx_r <= BIT_RST;
      else if (lk.cs_n)
         bit_idx_r <= BIT_RST;
      else if (frame_done)
         bit_idx_r <= BIT_RST;
      else
         bit_idx_r <= bit_idx_r + 5'h01;
   end

   // Enable follows select one clock later because the pin is registered
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dout_r    <= 1'b0;
         dout_oe_r <= 1'b0;
      end
      else
      begin
         dout_oe_r <= ~lk.cs_n;
         if (!lk.cs_n)
            dout_r <= frame_w[FRAME_LAST - bit_idx_r];
         else
            dout_r <= 1'b0;
      end
   end

   // Ready: the fall wins over the release when both land together
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         conversion_done_n_n_r <= PIN_IDLE;
      else if (conv && !full_ovf)
         conversion_done_n_n_r <= 1'b0;
      else if (pop || (per_cnt_r == CONVERSION_DONE_N_RISE))
         conversion_done_n_n_r <= 1'b1;
   end

   // Realign flag: a new misalignment beats the clear by a finished read
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         flag_r <= 1'b0;
      else if (misalign)
         flag_r <= 1'b1;
      else if (frame_done)
         flag_r <= 1'b0;
   end

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ovf_r     <= 1'b0;
         rd_done_r <= 1'b0;
         part_r    <= 1'b0;
      end
      else
      begin
         ovf_r     <= full_ovf;
         rd_done_r <= frame_done;
         part_r    <= lk.cs_n & (bit_idx_r != BIT_RST);
      end
   end

   assign lk.dout              = dout_r;
   assign lk.dout_oe           = dout_oe_r;
   assign lk.conversion_done_n = conversion_done_n_n_r;
   assign realign_flag_o       = flag_r;
   assign fifo_level_o         = level_r;
   assign overflow_o           = ovf_r;
   assign frame_read_o         = rd_done_r;
   assign partial_read_o       = part_r;
   assign conv_count_o         = conv_idx_r;

endmodule

// file: afr_host.sv
// Purpose: Host end: reads one whole frame after every ready fall,
//          issues alignment strobes, hands frames to the ref clock side.
// Assumes: One device on this select; link clock made by the bench.
// Notes:   Frame words cross by toggle; a frame is far longer than the
//          crossing, so the held word is stable when sampled.
`timescale 1ns/1ns
module afr_host
   import afr_pkg::*;
(
   afr_link_if.host              lk,
   input  wire logic             ref_clk_i,
   input  wire logic             nrst_i,
   input  wire logic             sync_req_i,
   output logic [FRAME_BITS-1:0] frame_o,
   output logic                  frame_valid_o,
   output logic                  realign_seen_o
);

   afr_hstate_t           st_r;
   logic                  conversion_done_n_q_r;
   logic                  conversion_done_n_fall;
   logic                  cs_n_r;
   logic [BIT_W-1:0]      cnt_r;
   logic                  smp_v_r;
   logic [BIT_W-1:0]      smp_cnt_r;
   logic [FRAME_BITS-1:0] shift_r;
   logic [FRAME_BITS-1:0] frame_lk_r;
   logic                  ftog_r;
   logic                  sreq_tog_r;
   logic [2:0]            sreq_s_r;
   logic                  sync_n_r;
   logic [2:0]            ftog_s_r;
   logic [FRAME_BITS-1:0] frame_r;
   logic                  fvalid_r;

   assign conversion_done_n_fall = conversion_done_n_q_r & ~lk.conversion_done_n;

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         conversion_done_n_q_r <= PIN_IDLE;
      else
         conversion_done_n_q_r <= lk.conversion_done_n;
   end

   // Select stays low for exactly one frame, every word included
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_r   <= AFR_IDLE;
         cs_n_r <= PIN_IDLE;
         cnt_r  <= BIT_RST;
      end
      else
      begin
         case (st_r)
            AFR_IDLE:
            begin
               if (conversion_done_n_fall)
               begin
                  st_r   <= AFR_READ;
                  cs_n_r <= 1'b0;
                  cnt_r  <= BIT_RST;
               end
            end
            AFR_READ:
            begin
               if (cnt_r == FRAME_LAST)
               begin
                  st_r   <= AFR_IDLE;
                  cs_n_r <= PIN_IDLE;
               end
               else
                  cnt_r <= cnt_r + 5'h01;
            end
            default:
            begin
               st_r   <= AFR_IDLE;
               cs_n_r <= PIN_IDLE;
            end
         endcase
      end
   end

   // Device answers one clock after it sees select, so sample one later
   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         smp_v_r   <= 1'b0;
         smp_cnt_r <= BIT_RST;
         shift_r   <= '0;
         frame_lk_r <= '0;
         ftog_r    <= 1'b0;
      end
      else
      begin
         smp_v_r <= ~cs_n_r;
         if (smp_v_r)
         begin
            shift_r <= {shift_r[FRAME_BITS-2:0], lk.dout_line};
            if (smp_cnt_r == FRAME_LAST)
            begin
               smp_cnt_r  <= BIT_RST;
               frame_lk_r <= {shift_r[FRAME_BITS-2:0], lk.dout_line};
               ftog_r     <= ~ftog_r;
            end
            else
               smp_cnt_r <= smp_cnt_r + 5'h01;
         end
      end
   end

   // Strobe request crosses as a toggle, then drives one low clock
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sreq_tog_r <= 1'b0;
      else if (sync_req_i)
         sreq_tog_r <= ~sreq_tog_r;
   end

   always_ff @(posedge lk.lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sreq_s_r <= 3'h0;
         sync_n_r <= PIN_IDLE;
      end
      else
      begin
         sreq_s_r <= {sreq_s_r[1:0], sreq_tog_r};
         sync_n_r <= ~(sreq_s_r[2] ^ sreq_s_r[1]);
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ftog_s_r <= 3'h0;
         frame_r  <= '0;
         fvalid_r <= 1'b0;
      end
      else
      begin
         ftog_s_r <= {ftog_s_r[1:0], ftog_r};
         fvalid_r <= ftog_s_r[2] ^ ftog_s_r[1];
         if (ftog_s_r[2] ^ ftog_s_r[1])
            frame_r <= frame_lk_r;
      end
   end

   // Select is driven per frame and never tied low, so no CRC is needed
   assign lk.cs_n        = cs_n_r;
   assign lk.sync_n      = sync_n_r;
   assign frame_o        = frame_r;
   assign frame_valid_o  = fvalid_r;
   assign realign_seen_o = frame_r[FRAME_BITS-1];

endmodule

// file: afr_sva.sv
// Purpose: Link checks between converter end and host end
// Assumes: One link clock domain; signals taken from the interface
// Notes:   Run lengths of select and ready are counted in helper flops
`timescale 1ns/1ns
module afr_sva
(
   input  wire logic lk_clk,
   input  wire logic nrst_i,
   input  wire logic cs_n,
   input  wire logic sync_n,
   input  wire logic dout_oe,
   input  wire logic conversion_done_n
);
   logic [7:0] sel_cnt_r;
   logic [7:0] low_cnt_r;

   always_ff @(posedge lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_cnt_r <= 8'h00;
      else if (cs_n)
         sel_cnt_r <= 8'h00;
      else
         sel_cnt_r <= sel_cnt_r + 8'h01;
   end

   always_ff @(posedge lk_clk or negedge nrst_i)
   begin
      if (!nrst_i)
         low_cnt_r <= 8'h00;
      else if (conversion_done_n)
         low_cnt_r <= 8'h00;
      else
         low_cnt_r <= low_cnt_r + 8'h01;
   end

   default clocking cb @(posedge lk_clk);
   endclocking
   default disable iff (!nrst_i);

   sequence s_strobe;
      $fell(sync_n) ##1 sync_n;
   endsequence

   sequence s_no_conv;
      (!$fell(conversion_done_n))[*8];
   endsequence

   dout_release_a: assert property ($past(cs_n) |-> !dout_oe)
      else $error("data line driven while deselected");
   dout_drive_a: assert property (!$past(cs_n) |-> dout_oe)
      else $error("data line not driven while selected");
   frame_len_a: assert property ($rose(cs_n) |-> sel_cnt_r == 8'h18)
      else $error("frame not 24 bits long");
   ready_rise_a: assert property ($rose(cs_n) |-> ##[0:2] conversion_done_n)
      else $error("ready stayed low after full frame");
   ready_low_a: assert property (low_cnt_r < 8'h40)
      else $error("ready low for a whole period");
   host_read_a: assert property
      ($fell(conversion_done_n) && cs_n |-> ##[1:2] !cs_n)
      else $error("ready fall not followed by a read");
   strobe_width_a: assert property ($fell(sync_n) |-> s_strobe)
      else $error("strobe not one cycle wide");
   sync_nostart_a: assert property (s_strobe |-> ##2 s_no_conv)
      else $error("strobe started a conversion");
endmodule

// file: test_adc_frame_readout_sync.sv
// Purpose: Self-checking bench: host end reads converter end; a second
//          converter end is driven by the bench to break host rules
// Assumes: Both converter ends share link clock and strobe
// Notes:   Frame contents predicted from the conversion index
`timescale 1ns/1ns
module test_adc_frame_readout_sync
   import afr_pkg::*;
   ;
   logic                  ref_clk_i;
   logic                  lk_clk;
   logic                  nrst_i;
   logic                  sync_req_i;
   logic [FRAME_BITS-1:0] frame_o;
   logic                  frame_valid_o;
   logic [1:0]            lvl2;
   logic                  ovf2;
   logic [WORD_W-1:0]     cnt1;
   logic [WORD_W-1:0]     cnt2;
   logic [7:0]            idx;
   logic                  rd_done2;
   logic                  part2;
   logic                  flag1;
   logic                  seen;
   int                    error_cnt;
   int                    num_checks;

   afr_link_if lk (.lk_clk(lk_clk));
   afr_link_if lk2 (.lk_clk(lk_clk));
   // Same strobe to both converter ends, as a group would be wired
   assign lk2.sync_n = lk.sync_n;

   afr_dev afr_dev_i (.lk(lk.dev), .nrst_i(nrst_i), .realign_flag_o(flag1),
      .fifo_level_o(), .overflow_o(), .frame_read_o(), .partial_read_o(),
      .conv_count_o(cnt1));
   afr_dev afr_dev_b_i (.lk(lk2.dev), .nrst_i(nrst_i), .realign_flag_o(),
      .fifo_level_o(lvl2), .overflow_o(ovf2), .frame_read_o(rd_done2),
      .partial_read_o(part2), .conv_count_o(cnt2));
   afr_host afr_host_i (.lk(lk.host), .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .sync_req_i(sync_req_i), .frame_o(frame_o),
      .frame_valid_o(frame_valid_o), .realign_seen_o(seen));
   afr_sva afr_sva_i (.lk_clk(lk_clk), .nrst_i(nrst_i), .cs_n(lk.cs_n),
      .sync_n(lk.sync_n), .dout_oe(lk.dout_oe),
      .conversion_done_n(lk.conversion_done_n));

   always #10 ref_clk_i = ~ref_clk_i;
   always #32 lk_clk = ~lk_clk;

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [23:0] mk(input logic f, input logic [7:0] i);
      return {f, 7'h00, i, i + 8'h01};
   endfunction

   task automatic get_frame(output logic [23:0] f);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      while (frame_valid_o !== 1'b1 && n < 9000);
      chk(24'(frame_valid_o), 24'h1);
      f = frame_o;
   endtask

   task automatic pulse_sync();
      @(posedge ref_clk_i);
      #2 sync_req_i = 1'b1;
      @(posedge ref_clk_i);
      #2 sync_req_i = 1'b0;
   endtask

   // Bench plays the host on the second link; n below 24 aborts a frame
   task automatic rd2(input int n, output logic [23:0] v);
      logic d;
      v = 24'h0;
      lk2.cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge lk_clk);
         #2;
         v = {v[22:0], lk2.dout_line};
      end
      lk2.cs_n = 1'b1;
      d = rd_done2;
      @(posedge lk_clk);
      #2;
      chk(24'({lk2.dout_oe, lk2.dout_line}), 24'h1);
      chk(24'({d, part2}), 24'({n == 24, n != 24}));
   endtask

   task automatic t_stream();
      logic [23:0] f;
      repeat (14)
      begin
         get_frame(f);
         chk(f, mk(1'b0, idx));
         idx++;
      end
   endtask

   // Unread results: ready falls only every second period
   task automatic t_overflow();
      int n;
      int falls;
      int ovfs;
      logic pr;
      n = 0;
      falls = 0;
      ovfs = 0;
      while (lvl2 !== 2'h2 && n < 300)
      begin
         @(posedge lk_clk);
         #2;
         n++;
      end
      chk(24'(lvl2), 24'h2);
      pr = lk2.conversion_done_n;
      repeat (312)
      begin
         @(posedge lk_clk);
         #2;
         falls += int'(pr && !lk2.conversion_done_n);
         ovfs += int'(ovf2);
         pr = lk2.conversion_done_n;
      end
      chk(24'(falls), 24'h2);
      chk(24'(ovfs), 24'h2);
   endtask

   task automatic t_partial();
      logic [23:0] a;
      logic [23:0] b;
      int n;
      n = 0;
      rd2(24, a);
      rd2(24, a);
      while (lk2.conversion_done_n !== 1'b0 && n < 200)
      begin
         @(posedge lk_clk);
         #2;
         n++;
      end
      chk(24'(lk2.conversion_done_n), 24'h0);
      rd2(10, a);
      rd2(24, b);
      chk(24'(a[9:0]), 24'(b[23:14]));
      chk(24'(b[7:0]), 24'(b[15:8] + 8'h01));
   endtask

   // Misplaced strobes raise the flag again after it was cleared
   task automatic t_sync();
      logic [23:0] f;
      pulse_sync();
      repeat (8) @(posedge lk_clk);
      #2;
      chk(24'(flag1), 24'h1);
      get_frame(f);
      chk(f, mk(1'b1, idx));
      chk(24'(seen), 24'h1);
      chk(24'(flag1), 24'h0);
      idx++;
      get_frame(f);
      chk(f, mk(1'b0, idx));
      chk(24'(seen), 24'h0);
      idx++;
      pulse_sync();
      get_frame(f);
      chk(f, mk(1'b1, idx));
      chk(24'(seen), 24'h1);
   endtask

   task automatic t_group();
      logic [7:0] p1;
      logic [7:0] p2;
      p1 = cnt1;
      p2 = cnt2;
      repeat (192)
      begin
         @(posedge lk_clk);
         #2;
         chk(24'(cnt1 != p1), 24'(cnt2 != p2));
         p1 = cnt1;
         p2 = cnt2;
      end
   endtask

   initial
   begin
      ref_clk_i = 1'b0;
      lk_clk = 1'b0;
      nrst_i = 1'b0;
      sync_req_i = 1'b0;
      lk2.cs_n = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      idx = 8'h00;
      // Held in slow-clock cycles so the link logic sees reset edges
      repeat (6) @(posedge lk_clk);
      chk(24'({lk.cs_n, lk.sync_n, lk.dout_oe}), 24'h6);
      #2 nrst_i = 1'b1;
      fork
         t_stream();
         begin
            t_overflow();
            t_partial();
         end
      join
      t_sync();
      t_group();
      summarize();
   end

   initial
   begin
      #300000;
      error_cnt++;
      summarize();
   end
endmodule
